//--- rtl/devirq_pkg.sv
`default_nettype none

package devirq_pkg;

	// ========================================================
	// register map
	localparam logic [9:0] ADDR_PATTERN_STATUS  = 10'h024;
	localparam logic [9:0] ADDR_CONV0_STATUS    = 10'h025;
	localparam logic [9:0] ADDR_CONV1_STATUS    = 10'h026;
	localparam logic [9:0] ADDR_CLOCK_STATUS    = 10'h027;
	localparam logic [9:0] ADDR_ENABLE          = 10'h030;
	localparam logic [9:0] ADDR_PIN_SEL         = 10'h031;

	// ========================================================
	// event index in the internal 8-bit vector
	localparam int EV_PATTERN  = 0;
	localparam int EV_C0_CAL   = 1;
	localparam int EV_C0_AMP   = 2;
	localparam int EV_C1_CAL   = 3;
	localparam int EV_C1_AMP   = 4;
	localparam int EV_DLL_LOST = 5;
	localparam int EV_DLL_LOCK = 6;
	localparam int EV_PLL_LOST = 7;
	localparam int NUM_EVENTS  = 8;

	// ========================================================
	// bit positions inside the status registers
	localparam int BIT_PATTERN  = 0;
	localparam int BIT_CAL      = 3;
	localparam int BIT_AMP      = 0;
	localparam int BIT_DLL_LOST = 5;
	localparam int BIT_DLL_LOCK = 4;
	localparam int BIT_PLL_LOST = 1;

	// ========================================================
	// reset values
	localparam logic [7:0] RST_ENABLE  = 8'h00;
	localparam logic [7:0] RST_PIN_SEL = 8'h00;
	localparam logic [7:0] RST_LATCH   = 8'h00;

	// register bus request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [9:0] addr;
		logic [7:0] wdata;
	} devirq_bus_s;

	// read decoder selection
	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_PATTERN,
		SEL_CONV0,
		SEL_CONV1,
		SEL_CLOCK,
		SEL_ENABLE,
		SEL_PIN
	} devirq_sel_e;

endpackage

`default_nettype wire

//--- rtl/devirq_cell.sv
`timescale 1ns/1ps
`default_nettype none

// one event: live or latched status with clear-on-one and pin routing
module devirq_cell (
	input  wire logic i_clk,     // register clock
	input  wire logic i_rst_b,   // sync reset, active low
	input  wire logic i_cond,    // live condition
	input  wire logic i_en,      // latch and pin enable
	input  wire logic i_sel,     // pin routing, 0 or 1
	input  wire logic i_clr,     // write of one to this bit
	output logic      o_flag,    // status as read
	output logic      o_req0,    // request on pin 0
	output logic      o_req1     // request on pin 1
);

	logic latch_q;
	logic latch_d;

	// set wins over clear so an event in the clear cycle survives
	always_comb begin
		latch_d = latch_q;
		if (!i_en) begin
			latch_d = 1'b0;
		end else if (i_cond) begin
			latch_d = 1'b1;
		end else if (i_clr) begin
			latch_d = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			latch_q <= 1'b0;
		end else begin
			latch_q <= latch_d;
		end
	end

	// disabled: live and never on a pin
	assign o_flag = i_en ? latch_q : i_cond;
	assign o_req0 = i_en & latch_q & ~i_sel;
	assign o_req1 = i_en & latch_q & i_sel;

endmodule

`default_nettype wire

//--- rtl/devirq_top.sv
// Behaviour
// (R1) pattern error bit 0, latched when enabled
// (R2) pattern bit live, no pin, when disabled
// (R3) conv0 cal done bit 3, live/latched
// (R4) conv0 amp error bit 0, live/latched
// (R5) conv1 cal done bit 3 latches when enabled
// (R6) conv1 amp error bit 0, live/latched
// (R7) delay loop unlock bit 5, live/latched
// (R8) delay loop locked bit 4 latches enabled
// (R9) delay loop locked live when disabled
// (R10) clock synth unlock bit 1, live/latched
// (R11) write one clears latched bit, zero ignored
// (R12) per-event pin select, 0 pin0, 1 pin1
// (R13) enables reset to zero, live mode
// (R14) pin low while any routed latch pending
// (R15) conv1 cal uses conv1 enable
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module devirq_top (
	input  wire logic       i_clk,             // 200 MHz register clock
	input  wire logic       i_rst_b,           // sync reset, active low
	input  wire logic [9:0] i_addr,            // register address
	input  wire logic [7:0] i_wdata,           // write data
	input  wire logic       i_wr,              // write strobe
	input  wire logic       i_rd,              // read strobe
	output logic      [7:0] o_rdata,           // read data, next cycle
	input  wire logic       i_real_pattern_err, // live pattern error
	input  wire logic       i_conv0_cal_done,  // conv0 cal finished
	input  wire logic       i_conv0_amp_err,   // conv0 amp protect
	input  wire logic       i_conv1_cal_done,  // conv1 cal finished
	input  wire logic       i_conv1_amp_err,   // conv1 amp protect
	input  wire logic       i_dll_unlocked,    // delay loop lost lock
	input  wire logic       i_dll_locked,      // delay loop locked
	input  wire logic       i_pll_unlocked,    // clock synth lost lock
	output logic            o_interrupt_pin_n0, // pin 0, active low
	output logic            o_interrupt_pin_n1  // pin 1, active low
);

	// ========================================================
	// request bundling
	devirq_pkg::devirq_bus_s bus;
	assign bus.wr    = i_wr;
	assign bus.rd    = i_rd;
	assign bus.addr  = i_addr;
	assign bus.wdata = i_wdata;

	// ========================================================
	// enable and routing registers
	logic [7:0] enable_q;
	logic [7:0] pin_sel_q;

	// enables start clear so every bit begins live
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			enable_q <= devirq_pkg::RST_ENABLE; // [R13]
		end else if (bus.wr && bus.addr == devirq_pkg::ADDR_ENABLE) begin
			enable_q <= bus.wdata;
		end
	end

	// routing starts on pin 0
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			pin_sel_q <= devirq_pkg::RST_PIN_SEL; // [R12]
		end else if (bus.wr && bus.addr == devirq_pkg::ADDR_PIN_SEL) begin
			pin_sel_q <= bus.wdata;
		end
	end

	// ========================================================
	// event conditions and clear strobes, in event order
	logic [7:0] cond;
	logic [7:0] clr;
	logic [7:0] flag;
	logic [7:0] req0;
	logic [7:0] req1;

	assign cond[devirq_pkg::EV_PATTERN]  = i_real_pattern_err;
	assign cond[devirq_pkg::EV_C0_CAL]   = i_conv0_cal_done;
	assign cond[devirq_pkg::EV_C0_AMP]   = i_conv0_amp_err;
	assign cond[devirq_pkg::EV_C1_CAL]   = i_conv1_cal_done;
	assign cond[devirq_pkg::EV_C1_AMP]   = i_conv1_amp_err;
	assign cond[devirq_pkg::EV_DLL_LOST] = i_dll_unlocked;
	assign cond[devirq_pkg::EV_DLL_LOCK] = i_dll_locked;
	assign cond[devirq_pkg::EV_PLL_LOST] = i_pll_unlocked;

	logic wr_pat;
	logic wr_c0;
	logic wr_c1;
	logic wr_clk;
	assign wr_pat = bus.wr && bus.addr == devirq_pkg::ADDR_PATTERN_STATUS;
	assign wr_c0  = bus.wr && bus.addr == devirq_pkg::ADDR_CONV0_STATUS;
	assign wr_c1  = bus.wr && bus.addr == devirq_pkg::ADDR_CONV1_STATUS;
	assign wr_clk = bus.wr && bus.addr == devirq_pkg::ADDR_CLOCK_STATUS;

	// writing one clears, zero leaves the bit alone
	assign clr[devirq_pkg::EV_PATTERN] =
		wr_pat & bus.wdata[devirq_pkg::BIT_PATTERN]; // [R11]
	assign clr[devirq_pkg::EV_C0_CAL] =
		wr_c0 & bus.wdata[devirq_pkg::BIT_CAL]; // [R11]
	assign clr[devirq_pkg::EV_C0_AMP] =
		wr_c0 & bus.wdata[devirq_pkg::BIT_AMP];
	assign clr[devirq_pkg::EV_C1_CAL] =
		wr_c1 & bus.wdata[devirq_pkg::BIT_CAL];
	assign clr[devirq_pkg::EV_C1_AMP] =
		wr_c1 & bus.wdata[devirq_pkg::BIT_AMP];
	assign clr[devirq_pkg::EV_DLL_LOST] =
		wr_clk & bus.wdata[devirq_pkg::BIT_DLL_LOST];
	assign clr[devirq_pkg::EV_DLL_LOCK] =
		wr_clk & bus.wdata[devirq_pkg::BIT_DLL_LOCK];
	assign clr[devirq_pkg::EV_PLL_LOST] =
		wr_clk & bus.wdata[devirq_pkg::BIT_PLL_LOST];

	// ========================================================
	// one cell per event; each uses its own enable, conv1 cal too
	genvar g;
	generate
		for (g = 0; g < devirq_pkg::NUM_EVENTS; g++) begin : g_ev
			devirq_cell u_cell (
				.i_clk   (i_clk),
				.i_rst_b (i_rst_b),
				.i_cond  (cond[g]),
				.i_en    (enable_q[g]),  // [R2] [R9] [R15]
				.i_sel   (pin_sel_q[g]), // [R12]
				.i_clr   (clr[g]),
				.o_flag  (flag[g]),      // [R1] [R3] [R4] [R5]
				.o_req0  (req0[g]),      // [R6] [R7] [R8] [R10]
				.o_req1  (req1[g])
			);
		end
	endgenerate

	// ========================================================
	// status register images
	logic [7:0] st_pat;
	logic [7:0] st_c0;
	logic [7:0] st_c1;
	logic [7:0] st_clk;

	// unlisted bits read zero
	always_comb begin
		st_pat = 8'h00;
		st_c0  = 8'h00;
		st_c1  = 8'h00;
		st_clk = 8'h00;
		st_pat[devirq_pkg::BIT_PATTERN]  = flag[devirq_pkg::EV_PATTERN];
		st_c0[devirq_pkg::BIT_CAL]       = flag[devirq_pkg::EV_C0_CAL];
		st_c0[devirq_pkg::BIT_AMP]       = flag[devirq_pkg::EV_C0_AMP];
		st_c1[devirq_pkg::BIT_CAL]       = flag[devirq_pkg::EV_C1_CAL];
		st_c1[devirq_pkg::BIT_AMP]       = flag[devirq_pkg::EV_C1_AMP];
		st_clk[devirq_pkg::BIT_DLL_LOST] = flag[devirq_pkg::EV_DLL_LOST];
		st_clk[devirq_pkg::BIT_DLL_LOCK] = flag[devirq_pkg::EV_DLL_LOCK];
		st_clk[devirq_pkg::BIT_PLL_LOST] = flag[devirq_pkg::EV_PLL_LOST];
	end

	// ========================================================
	// read path
	devirq_pkg::devirq_sel_e sel;

	always_comb begin
		case (bus.addr)
			devirq_pkg::ADDR_PATTERN_STATUS: sel = devirq_pkg::SEL_PATTERN;
			devirq_pkg::ADDR_CONV0_STATUS:   sel = devirq_pkg::SEL_CONV0;
			devirq_pkg::ADDR_CONV1_STATUS:   sel = devirq_pkg::SEL_CONV1;
			devirq_pkg::ADDR_CLOCK_STATUS:   sel = devirq_pkg::SEL_CLOCK;
			devirq_pkg::ADDR_ENABLE:         sel = devirq_pkg::SEL_ENABLE;
			devirq_pkg::ADDR_PIN_SEL:        sel = devirq_pkg::SEL_PIN;
			default:                         sel = devirq_pkg::SEL_NONE;
		endcase
	end

	logic [7:0] rdata_d;

	always_comb begin
		case (sel)
			devirq_pkg::SEL_PATTERN: rdata_d = st_pat;
			devirq_pkg::SEL_CONV0:   rdata_d = st_c0;
			devirq_pkg::SEL_CONV1:   rdata_d = st_c1;
			devirq_pkg::SEL_CLOCK:   rdata_d = st_clk;
			devirq_pkg::SEL_ENABLE:  rdata_d = enable_q;
			devirq_pkg::SEL_PIN:     rdata_d = pin_sel_q;
			default:                 rdata_d = 8'h00;
		endcase
	end

	// data held only in the cycle after the read; zero otherwise
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_rdata <= 8'h00;
		end else if (bus.rd) begin
			o_rdata <= rdata_d;
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// ========================================================
	// pins registered so they never glitch on the board
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_interrupt_pin_n0 <= 1'b1;
			o_interrupt_pin_n1 <= 1'b1;
		end else begin
			o_interrupt_pin_n0 <= ~(|req0); // [R14]
			o_interrupt_pin_n1 <= ~(|req1); // [R14]
		end
	end

endmodule

`default_nettype wire

//--- test/devirq_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================================
// port-level checks of the event status block
module devirq_sva (
	input wire logic       i_clk, // clock
	input wire logic       i_rst_b, // reset, active low
	input wire logic [9:0] i_addr, // address
	input wire logic [7:0] i_wdata, // write data
	input wire logic       i_wr, // write strobe
	input wire logic       i_rd, // read strobe
	input wire logic [7:0] o_rdata, // read data
	input wire logic       i_real_pattern_err, // event
	input wire logic       i_dll_unlocked, // event
	input wire logic       i_dll_locked, // event
	input wire logic       o_interrupt_pin_n0, // pin 0
	input wire logic       o_interrupt_pin_n1 // pin 1
);
	logic [7:0] en_q;
	logic [7:0] sel_q;

	// shadows, since no internal state is visible from here
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			en_q  <= 8'h00;
			sel_q <= 8'h00;
		end else if (i_wr && i_addr == devirq_pkg::ADDR_ENABLE) begin
			en_q <= i_wdata;
		end else if (i_wr && i_addr == devirq_pkg::ADDR_PIN_SEL) begin
			sel_q <= i_wdata;
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);

	// ========================================================
	// clear of the only enabled event, condition held low
	sequence s_clr;
		en_q == 8'h01 && i_wr && i_wdata[0] && !i_real_pattern_err
		&& i_addr == devirq_pkg::ADDR_PATTERN_STATUS
		##1 !i_real_pattern_err;
	endsequence

	pins_reset_a: assert property ($past(!i_rst_b) |->
		o_interrupt_pin_n0 && o_interrupt_pin_n1) else $error("pin low");
	live_pattern_a: assert property (i_rd && !en_q[0] &&
		i_addr == devirq_pkg::ADDR_PATTERN_STATUS |=>
		o_rdata[0] == $past(i_real_pattern_err)) else $error("not live");
	live_lock_a: assert property (i_rd && !en_q[6] &&
		i_addr == devirq_pkg::ADDR_CLOCK_STATUS |=>
		o_rdata[4] == $past(i_dll_locked)) else $error("lock not live");
	pin0_quiet_a: assert property ((en_q & ~sel_q) == 8'h00 [*3]
		|-> o_interrupt_pin_n0) else $error("pin 0 low");
	pin1_quiet_a: assert property ((en_q & sel_q) == 8'h00 [*3]
		|-> o_interrupt_pin_n1) else $error("pin 1 low");
	pattern_set_a: assert property (en_q[0] && i_real_pattern_err
		&& !(i_wr && i_addr == devirq_pkg::ADDR_ENABLE)
		|-> ##2 ($past(sel_q[0]) ? !o_interrupt_pin_n1
		: !o_interrupt_pin_n0)) else $error("pattern pin idle");
	pattern_clear_a: assert property (s_clr |-> ##1
		o_interrupt_pin_n0 && o_interrupt_pin_n1) else $error("not cleared");
	dll_lost_set_a: assert property (en_q[5] && i_dll_unlocked
		&& !(i_wr && i_addr == devirq_pkg::ADDR_ENABLE)
		|-> ##2 ($past(sel_q[5]) ? !o_interrupt_pin_n1
		: !o_interrupt_pin_n0)) else $error("unlock pin idle");
endmodule

bind devirq_top devirq_sva u_sva (.i_clk, .i_rst_b, .i_addr, .i_wdata,
	.i_wr, .i_rd, .o_rdata, .i_real_pattern_err, .i_dll_unlocked,
	.i_dll_locked, .o_interrupt_pin_n0, .o_interrupt_pin_n1);
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [9:0] ST_A [4] = '{devirq_pkg::ADDR_PATTERN_STATUS,
		devirq_pkg::ADDR_CONV0_STATUS, devirq_pkg::ADDR_CONV1_STATUS,
		devirq_pkg::ADDR_CLOCK_STATUS};
	logic       i_clk;
	logic       i_rst_b;
	logic [9:0] i_addr;
	logic [7:0] i_wdata;
	logic       i_wr;
	logic       i_rd;
	logic [7:0] o_rdata;
	logic [7:0] ev;
	logic       pin_n0;
	logic       pin_n1;
	int         error_cnt;
	int         n_compared;

	devirq_top DUT (.i_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd,
		.o_rdata, .i_real_pattern_err(ev[0]), .i_conv0_cal_done(ev[1]),
		.i_conv0_amp_err(ev[2]), .i_conv1_cal_done(ev[3]),
		.i_conv1_amp_err(ev[4]), .i_dll_unlocked(ev[5]),
		.i_dll_locked(ev[6]), .i_pll_unlocked(ev[7]),
		.o_interrupt_pin_n0(pin_n0), .o_interrupt_pin_n1(pin_n1));

	// ========================================================
	// helpers
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		@(posedge i_clk);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 chk(o_rdata, e);
	endtask
	// expects four status bytes, pattern register in the top byte
	task automatic rd_st(input logic [31:0] e);
		for (int i = 0; i < 4; i++) begin
			rd(ST_A[i], e[31-8*i -: 8]);
		end
	endtask
	task automatic pins(input logic [1:0] e);
		chk({6'h00, pin_n1, pin_n0}, {6'h00, e});
	endtask
	// one-cycle event pulse, then time for the registered pin
	task automatic pulse(input logic [7:0] v);
		@(posedge i_clk);
		ev <= v;
		@(posedge i_clk);
		ev <= 8'h00;
		repeat (2) @(posedge i_clk);
		#1;
	endtask
	task automatic stop_test();
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ========================================================
	// scenarios
	task automatic t_reset();
		rd_st(32'h0);
		rd(devirq_pkg::ADDR_ENABLE, 8'h00);
		rd(devirq_pkg::ADDR_PIN_SEL, 8'h00);
		pins(2'b11);
	endtask
	task automatic t_live();
		@(posedge i_clk);
		ev <= 8'hFF;
		rd_st(32'h01090932);
		pins(2'b11);
		@(posedge i_clk);
		ev <= 8'h00;
		rd_st(32'h0);
	endtask
	task automatic t_latch();
		wr(devirq_pkg::ADDR_ENABLE, 8'hFF);
		pulse(8'hFF);
		pins(2'b10);
		rd_st(32'h01090932);
		wr(ST_A[3], 8'h00);
		rd_st(32'h01090932);
		for (int i = 0; i < 4; i++) begin
			wr(ST_A[i], 8'hFF);
		end
		rd_st(32'h0);
		pins(2'b11);
	endtask
	// only the pattern event, steered to pin 1
	task automatic t_route();
		wr(devirq_pkg::ADDR_ENABLE, 8'h01);
		wr(devirq_pkg::ADDR_PIN_SEL, 8'h01);
		pulse(8'h01);
		pins(2'b01);
		rd(devirq_pkg::ADDR_PIN_SEL, 8'h01);
		wr(ST_A[0], 8'h01);
		rd(10'h3FF, 8'h00);
		pins(2'b11);
	endtask
	task automatic t_own();
		wr(devirq_pkg::ADDR_PIN_SEL, 8'h00);
		wr(devirq_pkg::ADDR_ENABLE, 8'h08);
		pulse(8'h0A);
		pins(2'b10);
		rd(ST_A[1], 8'h00);
		rd(ST_A[2], 8'h08);
		wr(ST_A[2], 8'h08);
		rd(ST_A[2], 8'h00);
		// clear while the event still stands: set wins
		@(posedge i_clk);
		ev <= 8'h08;
		wr(ST_A[2], 8'h08);
		rd(ST_A[2], 8'h08);
	endtask

	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	// watchdog, far beyond the about 115 cycles the run needs
	initial begin
		#20000;
		error_cnt++;
		stop_test();
	end
	initial begin
		i_rst_b = 1'b0;
		i_addr  = 10'h000;
		i_wdata = 8'h00;
		i_wr    = 1'b0;
		i_rd    = 1'b0;
		ev      = 8'h00;
		repeat (10) @(posedge i_clk);
		i_rst_b <= 1'b1;
		t_reset();
		t_live();
		t_latch();
		t_route();
		t_own();
		stop_test();
	end
endmodule
`default_nettype wire
